/* File: core/hold_cfg_if.sv */
// Shared hold timing carried to every warning hold cell
`timescale 1ns/1ps
interface hold_cfg_if;
	logic tick;
	logic noLimit;
	logic [6:0] holdTicks;
	modport src (output tick, output noLimit, output holdTicks);
	modport dst (input tick, input noLimit, input holdTicks);
endinterface : hold_cfg_if

/* File: core/servo_status_out.sv */
// Warning, status and divided pulse outputs of the servo drive
`timescale 1ns/1ps
module servo_status_out
	import servo_warn_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] loadFactor,
	input wire logic [7:0] regenFactor,
	input wire logic batteryLow,
	input wire logic upperFanStopped,
	input wire logic lowerFanStopped,
	input wire logic largeFrame,
	input wire logic servoOn,
	input wire logic encCommOk,
	input wire logic encCommErr,
	input wire logic scaleCommOk,
	input wire logic scaleCommErr,
	input wire logic encOverheat,
	input wire logic scaleAlarm,
	input wire logic oscDetect,
	input wire logic [15:0] capLifeLeft,
	input wire logic [15:0] fanLifeLeft,
	input wire logic posCmdActive,
	input wire logic speedLimited,
	input wire logic alarmActive,
	input wire logic alarmClearable,
	input wire logic encStep,
	input wire logic encDir,
	input wire logic encIndex,
	input wire logic scaleStep,
	input wire logic scaleDir,
	input wire logic scaleIndex,
	output logic warningOutA,
	output logic warningOutB,
	output logic posCmdFlag,
	output logic speedLimitFlag,
	output logic clearableAlarmFlag,
	output logic dividedPhaseAOut,
	output logic dividedPhaseBOut,
	output logic dividedPhaseZOut,
	output logic invertedZSingleEnded
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [12:0] ctrl_r;
	logic [10:0] mask_r;
	logic [15:0] thresh_r;
	logic [15:0] life_r;
	logic [31:0] div_r;
	logic [NUM_WARN-1:0] held;
	logic zSeen_r;
	logic zAlign_r;
	logic wrEn;
	logic mapped;
	logic [31:0] rdVal;

	assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_MASK) || (paddr == OFS_THRESH)
		|| (paddr == OFS_LIFE) || (paddr == OFS_DIV) || (paddr == OFS_STAT);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wrEn = psel && penable && pwrite && mapped;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RST;
			mask_r <= MASK_RST;
			thresh_r <= THRESH_RST;
			life_r <= LIFE_RST;
			div_r <= DIV_RST;
		end else if (wrEn) begin
			if (paddr == OFS_CTRL) begin
				ctrl_r <= pwdata[12:0];
			end else if (paddr == OFS_MASK) begin
				mask_r <= pwdata[10:0];
			end else if (paddr == OFS_THRESH) begin
				thresh_r <= pwdata[15:0];
			end else if (paddr == OFS_LIFE) begin
				life_r <= pwdata[15:0];
			end else if (paddr == OFS_DIV) begin
				div_r <= pwdata;
			end
		end
	end

	always_comb begin
		rdVal = 32'h0000_0000;
		if (paddr == OFS_CTRL) begin
			rdVal[12:0] = ctrl_r;
		end else if (paddr == OFS_MASK) begin
			rdVal[10:0] = mask_r;
		end else if (paddr == OFS_THRESH) begin
			rdVal[15:0] = thresh_r;
		end else if (paddr == OFS_LIFE) begin
			rdVal[15:0] = life_r;
		end else if (paddr == OFS_DIV) begin
			rdVal = div_r;
		end else if (paddr == OFS_STAT) begin
			rdVal[NUM_WARN-1:0] = held;
			rdVal[STAT_ZSEEN_BIT] = zSeen_r;
			rdVal[STAT_ALIGN_BIT] = zAlign_r;
		end
	end

	// Read data is caught in the setup cycle so the access needs no wait
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdVal;
		end
	end

	// ----------------------------------------------------------------
	// Time base and hold settings
	// ----------------------------------------------------------------
	logic [23:0] tickCnt_r;
	logic tick;
	logic [3:0] holdSec;
	hold_cfg_if cfg ();

	assign tick = (tickCnt_r == 24'(TICK_CYC - 1));
	always_ff @(posedge clk) begin
		if (!rst_n || tick) begin
			tickCnt_r <= 24'h000000;
		end else begin
			tickCnt_r <= tickCnt_r + 24'h000001;
		end
	end

	// Settings above ten seconds are clamped rather than refused
	assign holdSec = ctrl_r[CTRL_HOLD_LSB +: 4];
	assign cfg.tick = tick;
	assign cfg.noLimit = (holdSec == 4'h0);
	assign cfg.holdTicks = (holdSec > HOLD_MAX_SEC) ? 7'(HOLD_MAX_SEC * TICKS_PER_SEC)
		: 7'(holdSec * TICKS_PER_SEC);

	// ----------------------------------------------------------------
	// Warning detection
	// ----------------------------------------------------------------
	logic [3:0] fanCnt_r;
	logic fanStopped;
	logic [7:0] encErrCnt_r;
	logic [7:0] scaleErrCnt_r;
	logic [NUM_WARN-1:0] raw;
	logic [NUM_WARN-1:0] detect;

	// The upper fan of the large frame rests during servo off on purpose
	assign fanStopped = lowerFanStopped || (upperFanStopped && !(largeFrame && !servoOn));

	always_ff @(posedge clk) begin
		if (!rst_n || !fanStopped) begin
			fanCnt_r <= 4'h0;
		end else if (tick && fanCnt_r < 4'(FAN_TICKS)) begin
			fanCnt_r <= fanCnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || encCommOk) begin
			encErrCnt_r <= 8'h00;
		end else if (encCommErr && encErrCnt_r != 8'hff) begin
			encErrCnt_r <= encErrCnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || scaleCommOk) begin
			scaleErrCnt_r <= 8'h00;
		end else if (scaleCommErr && scaleErrCnt_r != 8'hff) begin
			scaleErrCnt_r <= scaleErrCnt_r + 8'h01;
		end
	end

	always_comb begin
		raw[0] = loadFactor >= LOAD_WARN_PCT;
		raw[1] = regenFactor >= LOAD_WARN_PCT;
		raw[2] = batteryLow;
		raw[3] = fanCnt_r >= 4'(FAN_TICKS);
		raw[4] = encErrCnt_r > thresh_r[7:0];
		raw[5] = encOverheat;
		raw[6] = oscDetect;
		raw[7] = (capLifeLeft < life_r) || (fanLifeLeft < life_r);
		raw[8] = scaleAlarm;
		raw[9] = scaleErrCnt_r > thresh_r[15:8];
	end

	for (genvar i = 0; i < NUM_WARN; i++) begin : g_warn
		assign detect[i] = raw[i] && !mask_r[MASK_POS[i]];
		warn_hold #(.FIXED_INF(FIXED_NO_LIMIT[i])) u_hold (
			.clk(clk),
			.rst_n(rst_n),
			.detect(detect[i]),
			.cfg(cfg.dst),
			.held(held[i])
		);
	end

	// ----------------------------------------------------------------
	// Warning routing and status flags
	// ----------------------------------------------------------------
	function automatic logic route(input logic [3:0] sel, input logic [NUM_WARN-1:0] w);
		logic r;
		r = 1'b0;
		if (sel == 4'h0) begin
			r = |w;
		end else if (sel <= ROUTE_MAX) begin
			r = w[sel - 4'h1];
		end
		return r;
	endfunction : route

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			warningOutA <= 1'b0;
			warningOutB <= 1'b0;
		end else begin
			warningOutA <= route(ctrl_r[CTRL_ROUTE_A_LSB +: 4], held);
			warningOutB <= route(ctrl_r[CTRL_ROUTE_B_LSB +: 4], held);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			posCmdFlag <= 1'b0;
			speedLimitFlag <= 1'b0;
			clearableAlarmFlag <= 1'b0;
		end else begin
			posCmdFlag <= posCmdActive;
			speedLimitFlag <= speedLimited;
			clearableAlarmFlag <= alarmActive && alarmClearable;
		end
	end

	// ----------------------------------------------------------------
	// Divided pulse output
	// ----------------------------------------------------------------
	logic srcScale;
	logic inStep;
	logic inDir;
	logic inIndex;
	logic [16:0] accSum;
	logic divHit;
	logic [15:0] acc_r;
	logic signed [CNT_W-1:0] pend_r;
	logic [1:0] gap_r;
	logic [1:0] quad_r;
	logic [1:0] revStep_r;
	logic outStep;
	zState_t zState_r;
	// A one-bit signed literal would sign-extend to minus one, so the step is sized
	localparam logic signed [CNT_W-1:0] PEND_ONE = CNT_W'(1);

	assign srcScale = ctrl_r[CTRL_SRC_BIT];
	assign inStep = srcScale ? scaleStep : encStep;
	assign inDir = srcScale ? scaleDir : encDir;
	assign inIndex = srcScale ? scaleIndex : encIndex;
	// Ratio must not exceed one: each input count yields at most one output step
	assign accSum = {1'b0, acc_r} + {1'b0, div_r[15:0]};
	assign divHit = inStep && (accSum >= {1'b0, div_r[31:16]});
	// Output edges are spaced so the quadrupled rate stays inside the limit
	assign outStep = (pend_r != '0) && (gap_r == 2'h0);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_r <= 16'h0000;
		end else if (divHit) begin
			acc_r <= 16'(accSum - {1'b0, div_r[31:16]});
		end else if (inStep) begin
			acc_r <= accSum[15:0];
		end
	end

	// Backlog saturates; a burst beyond it loses output counts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend_r <= '0;
		end else if (divHit && !outStep) begin
			if (inDir && pend_r != {1'b0, {(CNT_W-1){1'b1}}}) begin
				pend_r <= pend_r + PEND_ONE;
			end else if (!inDir && pend_r != {1'b1, {(CNT_W-1){1'b0}}}) begin
				pend_r <= pend_r - PEND_ONE;
			end
		end else if (outStep && !(divHit && (inDir == !pend_r[CNT_W-1]))) begin
			pend_r <= pend_r[CNT_W-1] ? pend_r + PEND_ONE : pend_r - PEND_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gap_r <= 2'h0;
			quad_r <= 2'h0;
			revStep_r <= 2'h0;
		end else if (outStep) begin
			gap_r <= 2'(EDGE_CYCLES - 1);
			quad_r <= pend_r[CNT_W-1] ? quad_r - 2'h1 : quad_r + 2'h1;
			revStep_r <= inIndex ? 2'h1 : revStep_r + 2'h1;
		end else begin
			gap_r <= (gap_r == 2'h0) ? 2'h0 : gap_r - 2'h1;
			revStep_r <= inIndex ? 2'h0 : revStep_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dividedPhaseAOut <= 1'b0;
			dividedPhaseBOut <= 1'b0;
		end else begin
			dividedPhaseAOut <= quad_r[0] ^ quad_r[1];
			dividedPhaseBOut <= quad_r[1];
		end
	end

	// Alignment is judged on the output steps of the previous turn
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			zState_r <= Z_IDLE;
			zAlign_r <= 1'b0;
			zSeen_r <= 1'b0;
		end else begin
			if (inIndex) begin
				zAlign_r <= (revStep_r == 2'h0);
				zSeen_r <= 1'b1;
			end
			case (zState_r)
				Z_IDLE: begin
					if (inIndex) begin
						zState_r <= (revStep_r == 2'h0) ? Z_WAIT_A : Z_WAIT_CNT;
					end
				end
				Z_WAIT_A: begin
					if (outStep) begin
						zState_r <= Z_IDLE;
					end
				end
				Z_WAIT_CNT: begin
					if (inStep) begin
						zState_r <= Z_IDLE;
					end
				end
				default: begin
					zState_r <= Z_IDLE;
				end
			endcase
		end
	end

	assign dividedPhaseZOut = (zState_r != Z_IDLE);
	assign invertedZSingleEnded = !dividedPhaseZOut;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_route_or_all: assert property ((ctrl_r[3:0] == 4'h0) |=>
		(warningOutA == |$past(held)))
		else $error("warning out A is not the OR of warnings");
	a_route_pick: assert property ((ctrl_r[7:4] inside {[4'h1:4'ha]}) |=>
		(warningOutB == $past(held[ctrl_r[7:4] - 4'h1])))
		else $error("warning out B routed wrongly");
	a_mask_blocks: assert property ((mask_r[7] && !held[0]) |=> !held[0])
		else $error("masked overload warning was set");
	a_load_thresh: assert property ((loadFactor >= 8'h55 && !mask_r[7]) |=> held[0])
		else $error("overload warning missed at 85 percent");
	a_fan_upper: assert property ((largeFrame && !servoOn && !lowerFanStopped)
		|=> (fanCnt_r == 4'h0))
		else $error("upper fan rest counted as a stop");
	a_comm_count: assert property ((encCommErr && !encCommOk && encErrCnt_r == thresh_r[7:0]
		&& encErrCnt_r != 8'hff && !mask_r[4]) |=> ##1 held[4])
		else $error("encoder comm warning not raised");
	a_alarm_flag: assert property ((alarmActive && alarmClearable) |=> clearableAlarmFlag
		##1 (clearableAlarmFlag || !$past(alarmActive && alarmClearable)))
		else $error("clearable alarm flag wrong");
	a_edge_spacing: assert property (outStep |=> !outStep ##1 !outStep)
		else $error("output edges closer than the rate limit");
	a_z_count_wide: assert property ((zState_r == Z_WAIT_CNT && inStep) |=>
		!dividedPhaseZOut && invertedZSingleEnded)
		else $error("unaligned Z longer than one count");

	c_warn_a_on: cover property ($rose(warningOutA));
	c_z_aligned: cover property ((zState_r == Z_WAIT_A) ##[1:20] outStep);
	c_hold_expire: cover property ($fell(held[0]));
	c_apb_write: cover property (wrEn && paddr == OFS_CTRL);
endmodule : servo_status_out

/* File: core/servo_warn_pkg.sv */
// Constants shared by the servo warning and status output logic
// ----------------------------------------------------------------------
// Notes on behaviour
// - Route select zero drives the OR of all unmasked warnings.
// - Route select 1..10 drives warning A0..A9; other values drive nothing.
// - A mask bit of one suppresses detection of its warning.
// - Mask bits: A0 7, A1 5, A2 0, A3 6, A4 4, A5 3, A6 9, A7 2, A8 8, A9 10.
// - Warnings hold for 1 to 10 seconds, or with no time limit.
// - Battery and lifetime warnings always hold with no time limit.
// - Overload and regeneration warnings at load factor 85 percent or more.
// - Fan warning after the fan stays stopped for one second.
// - Comm warnings when consecutive errors exceed threshold; good transfer restarts count.
// - Overheat and scale error warnings follow the encoder and scale alarms.
// - Lifetime warning when remaining capacitor or fan life is below limit.
// - Large frame upper fan stopping during servo off raises no warning.
// - Position command flag is on while a position command is applied.
// - Speed limited flag is on while torque control limits speed.
// - Clearable alarm flag is on when the active alarm can be cleared.
// - Divided A/B/Z pulses, quadrupled edge rate at most 4 Mpps.
// - Single ended Z output is the inverse of the Z output.
// - Z aligns with A when counts per turn divide by 4, else one count wide.
// - A warning output turns on when any warning routed to it occurs.
// ----------------------------------------------------------------------
package servo_warn_pkg;
	localparam int NUM_WARN = 10;
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_TIME_MS = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
	localparam int TICKS_PER_SEC = 1000 / TICK_TIME_MS;
	localparam int FAN_STOP_TIME_MS = 1000;
	localparam int FAN_TICKS = FAN_STOP_TIME_MS / TICK_TIME_MS;
	localparam int MIN_EDGE_NS = 250;
	localparam int EDGE_CYCLES = (MIN_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] LOAD_WARN_PCT = 8'h55;
	localparam logic [3:0] HOLD_MAX_SEC = 4'ha;
	localparam logic [3:0] ROUTE_MAX = 4'ha;
	// Warning order A0..A9 and the mask bit of each
	localparam int MASK_POS [NUM_WARN] = '{7, 5, 0, 6, 4, 3, 9, 2, 8, 10};
	localparam logic [NUM_WARN-1:0] FIXED_NO_LIMIT = 10'h084;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_THRESH = 8'h08;
	localparam logic [7:0] OFS_LIFE = 8'h0c;
	localparam logic [7:0] OFS_DIV = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	// Control and status fields
	localparam int CTRL_ROUTE_A_LSB = 0;
	localparam int CTRL_ROUTE_B_LSB = 4;
	localparam int CTRL_HOLD_LSB = 8;
	localparam int CTRL_SRC_BIT = 12;
	localparam int STAT_ZSEEN_BIT = 16;
	localparam int STAT_ALIGN_BIT = 17;
	// Reset values
	localparam logic [12:0] CTRL_RST = 13'h0100;
	localparam logic [10:0] MASK_RST = 11'h000;
	localparam logic [15:0] THRESH_RST = 16'h0808;
	localparam logic [15:0] LIFE_RST = 16'h0064;
	localparam logic [31:0] DIV_RST = 32'h0001_0001;
	typedef enum logic [1:0] {Z_IDLE = 2'b00, Z_WAIT_A = 2'b01, Z_WAIT_CNT = 2'b11} zState_t;
endpackage : servo_warn_pkg

/* File: core/warn_hold.sv */
// Hold cell that stretches one warning for the selected time
`timescale 1ns/1ps
module warn_hold #(
	parameter bit FIXED_INF = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic detect,
	hold_cfg_if.dst cfg,
	output logic held
);
	logic [6:0] cnt_r;

	// Time runs in 0.1 s ticks, so the hold may end up to one tick early
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			held <= 1'b0;
			cnt_r <= 7'h00;
		end else if (detect) begin
			held <= 1'b1;
			cnt_r <= cfg.holdTicks;
		end else if (held && !FIXED_INF && !cfg.noLimit && cfg.tick) begin
			if (cnt_r <= 7'h01) begin
				held <= 1'b0;
			end
			cnt_r <= cnt_r - 7'h01;
		end
	end

	a_hold_inf: assert property (@(posedge clk) disable iff (!rst_n)
		(held && (FIXED_INF || cfg.noLimit)) |=> held)
		else $error("held warning dropped with no time limit");
	a_hold_tick: assert property (@(posedge clk) disable iff (!rst_n)
		($fell(held)) |-> ($past(cfg.tick) && !$past(detect)))
		else $error("warning released off a tick");
endmodule : warn_hold

/* File: tb/host_ctrl_model.sv */
// Host controller model that decodes the divided pulse outputs
`timescale 1ns/1ps
module host_ctrl_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic phaseA,
	input wire logic phaseB,
	input wire logic phaseZ,
	input wire logic phaseZn,
	output logic [15:0] edgeCnt,
	output logic [15:0] trustCnt,
	output logic [15:0] minGap,
	output logic zSeen,
	output logic quadErr,
	output logic invErr
);
	logic [1:0] prevAb;
	logic [15:0] gap;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prevAb <= 2'b00;
			edgeCnt <= 16'h0000;
			trustCnt <= 16'h0000;
			minGap <= 16'hffff;
			gap <= 16'h0000;
			zSeen <= 1'b0;
			quadErr <= 1'b0;
			invErr <= 1'b0;
		end else begin
			prevAb <= {phaseA, phaseB};
			gap <= gap + 16'h0001;
			if ({phaseA, phaseB} != prevAb) begin
				edgeCnt <= edgeCnt + 16'h0001;
				gap <= 16'h0001;
				if (gap < minGap) begin
					minGap <= gap;
				end
				// Counts before the first index may be out of step
				if (zSeen) begin
					trustCnt <= trustCnt + 16'h0001;
				end
			end
			// A true quadrature pair never flips both phases at once
			if (({phaseA, phaseB} ^ prevAb) == 2'b11) begin
				quadErr <= 1'b1;
			end
			if (phaseZ) begin
				zSeen <= 1'b1;
			end
			if (phaseZn === phaseZ) begin
				invErr <= 1'b1;
			end
		end
	end
endmodule : host_ctrl_model

/* File: tb/tb.sv */
// Testbench for the servo warning, status and pulse outputs
`timescale 1ns/1ps
module tb;
	import servo_warn_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, loadFactor = 8'h00, regenFactor = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, batteryLow = 0, upperFanStopped = 0, lowerFanStopped = 0;
	logic largeFrame = 0, servoOn = 1, encCommOk = 0, encCommErr = 0, scaleCommOk = 0;
	logic scaleCommErr = 0, encOverheat = 0, scaleAlarm = 0, oscDetect = 0;
	logic [15:0] capLifeLeft = 16'h0064, fanLifeLeft = 16'h0064, edgeCnt, trustCnt, minGap;
	logic posCmdActive = 0, speedLimited = 0, alarmActive = 0, alarmClearable = 0;
	logic encStep = 0, encDir = 1, encIndex = 0, scaleStep = 0, scaleDir = 1, scaleIndex = 0;
	logic warningOutA, warningOutB, posCmdFlag, speedLimitFlag, clearableAlarmFlag;
	logic dividedPhaseAOut, dividedPhaseBOut, dividedPhaseZOut, invertedZSingleEnded;
	logic zSeen, quadErr, invErr;
	logic [9:0] sticky;
	int miscompares = 0, nCompared = 0, cycles = 0;
	always #50 clk = ~clk;
	servo_status_out #(.TICK_CYC(10)) servo_status_out_i (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .loadFactor(loadFactor),
		.regenFactor(regenFactor), .batteryLow(batteryLow), .upperFanStopped(upperFanStopped),
		.lowerFanStopped(lowerFanStopped), .largeFrame(largeFrame), .servoOn(servoOn),
		.encCommOk(encCommOk), .encCommErr(encCommErr), .scaleCommOk(scaleCommOk),
		.scaleCommErr(scaleCommErr), .encOverheat(encOverheat), .scaleAlarm(scaleAlarm),
		.oscDetect(oscDetect), .capLifeLeft(capLifeLeft), .fanLifeLeft(fanLifeLeft),
		.posCmdActive(posCmdActive), .speedLimited(speedLimited), .alarmActive(alarmActive),
		.alarmClearable(alarmClearable), .encStep(encStep), .encDir(encDir),
		.encIndex(encIndex), .scaleStep(scaleStep), .scaleDir(scaleDir),
		.scaleIndex(scaleIndex), .warningOutA(warningOutA), .warningOutB(warningOutB),
		.posCmdFlag(posCmdFlag), .speedLimitFlag(speedLimitFlag),
		.clearableAlarmFlag(clearableAlarmFlag), .dividedPhaseAOut(dividedPhaseAOut),
		.dividedPhaseBOut(dividedPhaseBOut), .dividedPhaseZOut(dividedPhaseZOut),
		.invertedZSingleEnded(invertedZSingleEnded));
	host_ctrl_model host_ctrl_model_i (.clk(clk), .rst_n(rst_n), .phaseA(dividedPhaseAOut),
		.phaseB(dividedPhaseBOut), .phaseZ(dividedPhaseZOut), .phaseZn(invertedZSingleEnded),
		.edgeCnt(edgeCnt), .trustCnt(trustCnt), .minGap(minGap), .zSeen(zSeen),
		.quadErr(quadErr), .invErr(invErr));
	// ----------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------
	task wrap_up;
		if (miscompares == 0 && nCompared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	task check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// The slave decides its own wait states; only the bench timeout ends a stall
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cyc
	task comm(input logic bad, input int n);
		repeat (n) begin
			@(posedge clk);
			encCommErr <= bad;
			scaleCommErr <= bad;
			encCommOk <= ~bad;
			scaleCommOk <= ~bad;
			@(posedge clk);
			{encCommErr, scaleCommErr, encCommOk, scaleCommOk} <= 4'h0;
		end
	endtask : comm
	task conds(input logic on);
		@(posedge clk);
		loadFactor <= on ? 8'h55 : 8'h54;
		regenFactor <= on ? 8'h55 : 8'h54;
		{batteryLow, upperFanStopped, lowerFanStopped} <= {3{on}};
		{encOverheat, scaleAlarm, oscDetect} <= {3{on}};
		capLifeLeft <= on ? 16'h0063 : 16'h0064;
		fanLifeLeft <= on ? 16'h0063 : 16'h0064;
		comm(on, on ? 9 : 1);
	endtask : conds
	task step(input logic src, input int n);
		repeat (n) begin
			@(posedge clk);
			encStep <= ~src;
			scaleStep <= src;
			@(posedge clk);
			{encStep, scaleStep} <= 2'b00;
			wait_cyc(2);
		end
	endtask : step
	task index;
		@(posedge clk);
		encIndex <= 1'b1;
		@(posedge clk);
		encIndex <= 1'b0;
	endtask : index
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			wrap_up;
		end
	end
	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		wait_cyc(16);
		rst_n <= 1'b1;
		check(invertedZSingleEnded, 1'b1);
		apb(0, OFS_CTRL, 0); check(q, 32'h0000_0100);
		apb(0, OFS_THRESH, 0); check(q, 32'h0000_0808);
		apb(0, OFS_DIV, 0); check(q, 32'h0001_0001);
		apb(0, 8'h18, 0); check(e, 1'b1);
		sticky = 10'h000;
		// Only one warning unmasked at a time, so each mask position is pinned
		for (int i = 0; i < NUM_WARN; i++) begin
			apb(1, OFS_MASK, 32'h7ff & ~(32'h1 << MASK_POS[i]));
			apb(1, OFS_CTRL, 32'h100 | ((i + 1) << 4));
			conds(1);
			wait_cyc(120);
			apb(0, OFS_STAT, 0);
			check(q[9:0], sticky | (10'h1 << i));
			check(warningOutA, 1'b1);
			check(warningOutB, 1'b1);
			conds(0);
			wait_cyc(40);
			apb(0, OFS_STAT, 0);
			check(q[i], 1'b1);
			wait_cyc(80);
			if (i == 2 || i == 7) sticky[i] = 1'b1;
			apb(0, OFS_STAT, 0);
			check(q[9:0], sticky);
			check(warningOutB, sticky[i]);
		end
		// Route B to the held battery warning first, so the refused value has a level to drop
		apb(1, OFS_CTRL, 32'h130);
		wait_cyc(2);
		check(warningOutB, 1'b1);
		apb(1, OFS_CTRL, 32'h1b0);
		wait_cyc(2);
		check(warningOutB, 1'b0);
		apb(1, OFS_MASK, 32'h7bf);
		largeFrame <= 1'b1;
		servoOn <= 1'b0;
		upperFanStopped <= 1'b1;
		wait_cyc(130);
		apb(0, OFS_STAT, 0); check(q[3], 1'b0);
		servoOn <= 1'b1;
		wait_cyc(130);
		apb(0, OFS_STAT, 0); check(q[3], 1'b1);
		upperFanStopped <= 1'b0;
		apb(1, OFS_MASK, 32'h7ef);
		comm(1, 8); comm(0, 1); comm(1, 8); wait_cyc(4);
		apb(0, OFS_STAT, 0); check(q[4], 1'b0);
		comm(1, 1); wait_cyc(4);
		apb(0, OFS_STAT, 0); check(q[4], 1'b1);
		comm(0, 1);
		apb(1, OFS_CTRL, 32'h000);
		apb(1, OFS_MASK, 32'h5ff);
		oscDetect <= 1'b1;
		wait_cyc(5);
		oscDetect <= 1'b0;
		wait_cyc(150);
		apb(0, OFS_STAT, 0); check(q[6], 1'b1);
		for (int k = 0; k < 4; k++) begin
			{alarmActive, speedLimited} <= {2{k[1]}};
			{alarmClearable, posCmdActive} <= {2{k[0]}};
			wait_cyc(3);
			check(posCmdFlag, k[0]);
			check(speedLimitFlag, k[1]);
			check(clearableAlarmFlag, k[0] & k[1]);
		end
		step(0, 8); index; step(0, 1); wait_cyc(8);
		apb(0, OFS_STAT, 0); check(q[17:16], 2'b11);
		step(0, 6); index; step(0, 1); wait_cyc(8);
		apb(0, OFS_STAT, 0); check(q[17], 1'b0);
		apb(1, OFS_CTRL, 32'h1000);
		step(1, 4);
		// Back to back counts build a backlog, so the edge spacing limit is exercised
		scaleStep <= 1'b1;
		wait_cyc(4);
		scaleStep <= 1'b0;
		wait_cyc(20);
		check(edgeCnt, 16'd24);
		check(trustCnt, 16'd16);
		check(minGap >= EDGE_CYCLES, 1'b1);
		check(quadErr, 1'b0);
		check(invErr, 1'b0);
		wrap_up;
	end
endmodule : tb
